// ---- common/sre_regs.svh ----
// Behaviour
// - Words carry an extended Hamming code: single errors corrected, double errors detected.
// - Write check bits are data times transposed data part of the check matrix.
// - Stored codeword is data bits followed by check bits.
// - Read syndrome is codeword times transposed full matrix; nonzero means error.
// - A correctable syndrome names the failing bit; a failing data bit is inverted before return, check bits are not.
// - 8-bit words use five check bits; c0 covers d3 to d7.
// - 16-bit words use six check bits; c0 covers d8 to d15.
// - 32-bit words use seven check bits; c0 covers d18 to d31.
// - 35-bit words use seven check bits; c0 covers d20 to d34.
// - 136-bit words have their own matrix; each check bit covers its row.
// - Two flipped bits log a double error and data returns uncorrected.
// - With data override set, an indirect write stores the write word at target.
// - Port A go launches an indirect access; port B go too when dual ported.
// - Checking on: normal writes make correct check bits, readable in two registers.
// - Checking off: normal writes make no check bits, no error is flagged.
// - Data written unchecked then read checked shows an error through mismatched bits.
// - Reads return written data with one flip; two flips log a double error.
// - Only a DMA-attached RAM shows normal-port check bits; others indirect only.
// - A stalled indirect access aborts after a fixed 2048-cycle watchdog.
// - Access setup selects read or write, and data and check overrides separately.
`ifndef SRE_REGS_SVH
`define SRE_REGS_SVH

// ==========================================================
// Sizes
`define SRE_MAX_DATA 136
`define SRE_MAX_CHK 9
`define SRE_MAX_ADDR 16
`define SRE_CHK_REG_W 8

// ==========================================================
// Timing
`define SRE_WDOG_CYCLES 2048
`define SRE_WDOG_W 12

// ==========================================================
// Reset values
`define SRE_FLAG_RST 1'b0
`define SRE_CNT_RST 12'h000

`endif

// ---- common/sre_pkg.sv ----
`include "sre_regs.svh"

package sre_pkg;

    // ==========================================================
    // Types
    typedef enum logic [0:0]
    {
        SRE_IDLE = 1'b0,
        SRE_BUSY = 1'b1
    } sre_fsm_t;

    typedef logic [`SRE_MAX_CHK-1:0][`SRE_MAX_DATA-1:0] sre_hmat_t;

    typedef struct packed
    {
        logic direction_flag;
        logic data_override_flag;
        logic check_override_flag;
    } sre_setup_t;

    typedef struct packed
    {
        logic [`SRE_MAX_DATA-1:0] data;
        logic sbe;
        logic dbe;
    } sre_dec_t;

    typedef struct packed
    {
        sre_fsm_t fsm;
        logic [`SRE_WDOG_W-1:0] wd_cnt;
        logic sbe_flag;
        logic dbe_flag;
        logic tmo_flag;
        logic [`SRE_MAX_ADDR-1:0] err_addr;
        logic [`SRE_MAX_DATA-1:0] rdata;
        logic rvalid;
        logic [`SRE_MAX_DATA-1:0] ind_data;
        logic [`SRE_MAX_CHK-1:0] chk;
        logic done;
    } sre_state_t;

    // ==========================================================
    // Matrix helpers
    function automatic int sre_chk_width(input int w);
        case (w)
            8: return 5;
            16: return 6;
            32: return 7;
            35: return 7;
            default: return 9;
        endcase
    endfunction : sre_chk_width

    // Rows of the data part of the parity-check matrix, bit j is column dj
    function automatic sre_hmat_t sre_hmat(input int w);
        sre_hmat_t m;
        logic [8:0] v;
        int j;
        m = '0;
        j = 0;
        case (w)
            8:
            begin
                m[0][7:0] = 8'hF8;
                m[1][7:0] = 8'hE6;
                m[2][7:0] = 8'h9D;
                m[3][7:0] = 8'h57;
                m[4][7:0] = 8'h2B;
            end
            16:
            begin
                m[0][15:0] = 16'hFF00;
                m[1][15:0] = 16'hF0F0;
                m[2][15:0] = 16'h8E8E;
                m[3][15:0] = 16'h496D;
                m[4][15:0] = 16'h255B;
                m[5][15:0] = 16'h12B7;
            end
            32:
            begin
                m[0][31:0] = 32'hFFFC0000;
                m[1][31:0] = 32'hF803FE00;
                m[2][31:0] = 32'h8783C1F0;
                m[3][31:0] = 32'h4472398E;
                m[4][31:0] = 32'h224D266D;
                m[5][31:0] = 32'h1128955B;
                m[6][31:0] = 32'h08944AB7;
            end
            35:
            begin
                m[0][34:0] = 35'h7FFF00000;
                m[1][34:0] = 35'h7C00FFC00;
                m[2][34:0] = 35'h43C0F03F0;
                m[3][34:0] = 35'h22388E38E;
                m[4][34:0] = 35'h112649A6D;
                m[5][34:0] = 35'h08952555B;
                m[6][34:0] = 35'h044B12CB7;
            end
            default:
            begin
                // Distinct odd-weight columns keep single and double errors apart
                for (int i = 0; i < 512; i++)
                begin
                    v = 9'(i);
                    if (($countones(v) >= 3) && ($countones(v) % 2 == 1) && (j < 136))
                    begin
                        for (int r = 0; r < 9; r++)
                        begin
                            m[r][j] = v[r];
                        end
                        j++;
                    end
                end
            end
        endcase
        return m;
    endfunction : sre_hmat

endpackage : sre_pkg

// ---- design/sre_secded_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sre_regs.svh"

module sre_secded_ram
    import sre_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 8,
    parameter bit DUAL_PORT = 1'b0,
    parameter bit DMA_ATTACHED = 1'b1
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Bus master memory port
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    input wire logic [DATA_W-1:0] mem_wdata_i,
    output logic [DATA_W-1:0] mem_rdata_o,
    output logic mem_rvalid_o,
    // Control
    input wire logic check_en_i,
    input wire sre_setup_t access_setup_i,
    input wire logic port_a_go_i,
    input wire logic port_b_go_i,
    input wire logic [ADDR_W-1:0] target_addr_i,
    input wire logic [DATA_W-1:0] write_word_regs_i,
    input wire logic [sre_chk_width(DATA_W)-1:0] write_check_i,
    input wire logic wdog_en_i,
    input wire logic mem_alive_i,
    input wire logic sbe_clear_i,
    input wire logic dbe_clear_i,
    input wire logic tmo_clear_i,
    // Status
    output logic ind_busy_o,
    output logic ind_done_o,
    output logic [DATA_W-1:0] read_word_o,
    output logic [`SRE_CHK_REG_W-1:0] read_check_reg_lo_o,
    output logic [`SRE_CHK_REG_W-1:0] read_check_reg_hi_o,
    output logic sbe_flag_o,
    output logic dbe_flag_o,
    output logic tmo_flag_o,
    output logic [ADDR_W-1:0] err_addr_o
);

    // ==========================================================
    // Code geometry
    localparam int CHK_W = sre_chk_width(DATA_W);
    localparam int CW = DATA_W + CHK_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam sre_hmat_t HM = sre_hmat(DATA_W);
    localparam logic [`SRE_WDOG_W-1:0] WDOG_LAST = `SRE_WDOG_W'(`SRE_WDOG_CYCLES - 1);

    // ==========================================================
    // Encoder and decoder
    function automatic logic [CHK_W-1:0] sre_enc(input logic [DATA_W-1:0] d);
        logic [CHK_W-1:0] c;
        c = '0;
        for (int r = 0; r < CHK_W; r++)
        begin
            c[r] = ^(d & HM[r][DATA_W-1:0]);
        end
        return c;
    endfunction : sre_enc

    function automatic sre_dec_t sre_dec(input logic [CW-1:0] cw);
        sre_dec_t o;
        logic [DATA_W-1:0] d;
        logic [CHK_W-1:0] s;
        logic [CHK_W-1:0] col;
        logic hit;
        o = '0;
        d = cw[CW-1:CHK_W];
        // Recomputed bits xor stored bits equals codeword times full matrix
        s = sre_enc(d) ^ cw[CHK_W-1:0];
        hit = 1'b0;
        for (int j = 0; j < DATA_W; j++)
        begin
            for (int r = 0; r < CHK_W; r++)
            begin
                col[r] = HM[r][j];
            end
            if ((s != '0) && (s == col))
            begin
                d[j] = ~d[j];
                hit = 1'b1;
            end
        end
        // A lone syndrome bit is a flipped check bit; data is already good
        if ($countones(s) == 1)
        begin
            hit = 1'b1;
        end
        o.data[DATA_W-1:0] = d;
        o.sbe = hit;
        o.dbe = (s != '0) && !hit;
        return o;
    endfunction : sre_dec

    // ==========================================================
    // Storage
    logic [CW-1:0] mem [0:DEPTH-1];
    logic [CW-1:0] n_cw;
    logic [CW-1:0] i_cw;
    sre_dec_t n_dec;
    sre_dec_t i_dec;
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [CW-1:0] mem_wd;

    assign n_cw = mem[mem_addr_i];
    assign i_cw = mem[target_addr_i];
    assign n_dec = sre_dec(n_cw);
    assign i_dec = sre_dec(i_cw);

    always_ff @(posedge clk_i)
    begin
        if (mem_we)
        begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ==========================================================
    // Control state
    sre_state_t s_reg;
    sre_state_t s_next;
    logic go;
    logic ind_fire;
    logic [DATA_W-1:0] i_wdata;
    logic [CHK_W-1:0] i_wchk;
    logic [CHK_W-1:0] n_wchk;
    logic set_sbe;
    logic set_dbe;
    logic set_tmo;

    assign go = port_a_go_i || (DUAL_PORT && port_b_go_i);
    // Bus master has priority; indirect work waits for an idle port
    assign ind_fire = (s_reg.fsm == SRE_BUSY) && !mem_req_i && mem_alive_i;

    always_comb
    begin
        s_next = s_reg;
        s_next.rvalid = 1'b0;
        s_next.done = 1'b0;
        mem_we = 1'b0;
        mem_wa = mem_addr_i;
        mem_wd = n_cw;
        set_sbe = 1'b0;
        set_dbe = 1'b0;
        set_tmo = 1'b0;
        i_wdata = '0;
        i_wchk = '0;
        n_wchk = '0;

        // Normal memory port
        if (mem_req_i && mem_we_i)
        begin
            // Unchecked writes keep the old bits, so a later checked read mismatches
            n_wchk = check_en_i ? sre_enc(mem_wdata_i) : n_cw[CHK_W-1:0];
            mem_we = 1'b1;
            mem_wd = {mem_wdata_i, n_wchk};
            if (DMA_ATTACHED)
            begin
                s_next.chk = `SRE_MAX_CHK'(n_wchk);
            end
        end
        else if (mem_req_i)
        begin
            s_next.rvalid = 1'b1;
            if (check_en_i)
            begin
                s_next.rdata = n_dec.data;
                set_sbe = n_dec.sbe;
                set_dbe = n_dec.dbe;
                if (n_dec.sbe || n_dec.dbe)
                begin
                    s_next.err_addr = `SRE_MAX_ADDR'(mem_addr_i);
                end
            end
            else
            begin
                s_next.rdata = '0;
                s_next.rdata[DATA_W-1:0] = n_cw[CW-1:CHK_W];
            end
            if (DMA_ATTACHED)
            begin
                s_next.chk = `SRE_MAX_CHK'(n_cw[CHK_W-1:0]);
            end
        end

        // Indirect access sequencer
        case (s_reg.fsm)
            SRE_IDLE:
            begin
                s_next.wd_cnt = `SRE_CNT_RST;
                if (go)
                begin
                    s_next.fsm = SRE_BUSY;
                end
            end
            SRE_BUSY:
            begin
                if (ind_fire)
                begin
                    s_next.fsm = SRE_IDLE;
                    s_next.done = 1'b1;
                    if (access_setup_i.direction_flag)
                    begin
                        i_wdata = access_setup_i.data_override_flag ?
                            write_word_regs_i : i_cw[CW-1:CHK_W];
                        if (access_setup_i.check_override_flag)
                        begin
                            i_wchk = write_check_i;
                        end
                        else
                        begin
                            i_wchk = check_en_i ? sre_enc(i_wdata) : i_cw[CHK_W-1:0];
                        end
                        mem_we = 1'b1;
                        mem_wa = target_addr_i;
                        mem_wd = {i_wdata, i_wchk};
                        s_next.chk = `SRE_MAX_CHK'(i_wchk);
                    end
                    else
                    begin
                        s_next.chk = `SRE_MAX_CHK'(i_cw[CHK_W-1:0]);
                        s_next.ind_data = '0;
                        if (check_en_i)
                        begin
                            s_next.ind_data = i_dec.data;
                            set_sbe = i_dec.sbe;
                            set_dbe = i_dec.dbe;
                            if (i_dec.sbe || i_dec.dbe)
                            begin
                                s_next.err_addr = `SRE_MAX_ADDR'(target_addr_i);
                            end
                        end
                        else
                        begin
                            s_next.ind_data[DATA_W-1:0] = i_cw[CW-1:CHK_W];
                        end
                    end
                end
                else if (wdog_en_i)
                begin
                    // Fixed interval, not software programmable
                    if (s_reg.wd_cnt == WDOG_LAST)
                    begin
                        s_next.fsm = SRE_IDLE;
                        set_tmo = 1'b1;
                    end
                    else
                    begin
                        s_next.wd_cnt = s_reg.wd_cnt + `SRE_WDOG_W'(1);
                    end
                end
            end
            default:
            begin
                s_next.fsm = SRE_IDLE;
            end
        endcase

        // Sticky flags, a set in the clearing cycle wins
        s_next.sbe_flag = (s_reg.sbe_flag && !sbe_clear_i) || set_sbe;
        s_next.dbe_flag = (s_reg.dbe_flag && !dbe_clear_i) || set_dbe;
        s_next.tmo_flag = (s_reg.tmo_flag && !tmo_clear_i) || set_tmo;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            s_reg <= '0;
            s_reg.fsm <= SRE_IDLE;
            s_reg.wd_cnt <= `SRE_CNT_RST;
            s_reg.sbe_flag <= `SRE_FLAG_RST;
            s_reg.dbe_flag <= `SRE_FLAG_RST;
            s_reg.tmo_flag <= `SRE_FLAG_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    logic [2*`SRE_CHK_REG_W-1:0] chk_pad;

    assign chk_pad = (2*`SRE_CHK_REG_W)'(s_reg.chk);
    assign mem_rdata_o = s_reg.rdata[DATA_W-1:0];
    assign mem_rvalid_o = s_reg.rvalid;
    assign ind_busy_o = (s_reg.fsm == SRE_BUSY);
    assign ind_done_o = s_reg.done;
    assign read_word_o = s_reg.ind_data[DATA_W-1:0];
    assign read_check_reg_lo_o = chk_pad[`SRE_CHK_REG_W-1:0];
    assign read_check_reg_hi_o = chk_pad[2*`SRE_CHK_REG_W-1:`SRE_CHK_REG_W];
    assign sbe_flag_o = s_reg.sbe_flag;
    assign dbe_flag_o = s_reg.dbe_flag;
    assign tmo_flag_o = s_reg.tmo_flag;
    assign err_addr_o = s_reg.err_addr[ADDR_W-1:0];

endmodule : sre_secded_ram

`default_nettype wire

// ---- tb/sre_secded_ram_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

module sre_secded_ram_props
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Memory port
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    input wire logic mem_rvalid_o,
    // Control
    input wire logic check_en_i,
    input wire logic port_a_go_i,
    input wire logic wdog_en_i,
    input wire logic mem_alive_i,
    // Status
    input wire logic ind_busy_o,
    input wire logic ind_done_o,
    input wire logic sbe_flag_o,
    input wire logic dbe_flag_o,
    input wire logic tmo_flag_o,
    input wire logic [ADDR_W-1:0] err_addr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // ==========================================================
    // Stalled busy cycles; a busy bus counts as a stall too
    logic [12:0] stall_cnt_reg;
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || !(ind_busy_o && wdog_en_i && (mem_req_i || !mem_alive_i)))
            stall_cnt_reg <= 13'h0000;
        else
            stall_cnt_reg <= stall_cnt_reg + 13'h0001;
    end

    // ==========================================================
    // Properties
    property p_read_answer;
        mem_req_i && !mem_we_i |=> mem_rvalid_o;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read request not answered");
    property p_answer_cause;
        mem_rvalid_o |-> $past(mem_req_i && !mem_we_i);
    endproperty
    a_answer_cause: assert property (p_answer_cause)
        else $error("read answer without request");
    property p_flags_need_check;
        $rose(sbe_flag_o) || $rose(dbe_flag_o) |-> $past(check_en_i);
    endproperty
    a_flags_need_check: assert property (p_flags_need_check)
        else $error("error flag raised with checking off");
    property p_go_busy;
        port_a_go_i && !ind_busy_o |=> ind_busy_o;
    endproperty
    a_go_busy: assert property (p_go_busy)
        else $error("go did not start access");
    property p_done_shape;
        ind_done_o |-> !ind_busy_o && $past(ind_busy_o) ##1 !ind_done_o;
    endproperty
    a_done_shape: assert property (p_done_shape)
        else $error("done pulse malformed");
    property p_exec;
        ind_busy_o && !mem_req_i && mem_alive_i |=> ind_done_o;
    endproperty
    a_exec: assert property (p_exec)
        else $error("indirect access not executed on idle bus");
    property p_watchdog;
        stall_cnt_reg == 13'h0800 |-> tmo_flag_o && !ind_busy_o && !ind_done_o;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("stalled access not aborted");
    property p_err_addr;
        mem_rvalid_o && ($rose(sbe_flag_o) || $rose(dbe_flag_o)) |-> err_addr_o == $past(mem_addr_i);
    endproperty
    a_err_addr: assert property (p_err_addr)
        else $error("error address not logged");
endmodule : sre_secded_ram_props

`default_nettype wire

// ---- tb/sre_bus_master.sv ----
`timescale 1ns/100ps
`default_nettype none

module sre_bus_master
#(
    parameter int DW = 8,
    parameter int AW = 4
)
(
    // Clock
    input wire logic clk_i,
    // Memory port
    output logic req_o,
    output logic we_o,
    output logic [AW-1:0] addr_o,
    output logic [DW-1:0] wdata_o,
    input wire logic [DW-1:0] rdata_i,
    input wire logic rvalid_i
);
    initial
    begin
        req_o = 1'b0;
        we_o = 1'b0;
        addr_o = '0;
        wdata_o = '0;
    end

    // ==========================================================
    // One access; released address and data lines show the inverse of the last value, write enable holds
    task automatic access(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                          output logic [DW-1:0] q, output logic ok);
        @(posedge clk_i);
        req_o <= 1'b1;
        we_o <= w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        req_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        @(negedge clk_i);
        q = rdata_i;
        ok = rvalid_i;
    endtask : access
endmodule : sre_bus_master

`default_nettype wire

// ---- tb/sre_secded_ram_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module sre_secded_ram_tb_top
    import sre_pkg::*;
;
    localparam int DW = 8;
    localparam int AW = 4;
    localparam logic [7:0] ROW [5] = '{8'hF8, 8'hE6, 8'h9D, 8'h57, 8'h2B};

    logic clk_i, resetn_i, req, we, rvalid, check_en, go_a, go_b, wdog_en, alive;
    logic sbe_clr, dbe_clr, tmo_clr, busy, done, sbe, dbe, tmo, ok;
    logic [AW-1:0] addr, taddr, eaddr;
    logic [DW-1:0] wdata, rdata, wword, rword, q, d, x;
    logic [DW-1:0] img [16];
    logic [4:0] wchk;
    logic [7:0] chk_lo;
    logic [7:0] chk_hi;
    sre_setup_t setup;
    int mismatches, checks, cycles, k, t0;

    sre_secded_ram #(.DATA_W(DW), .ADDR_W(AW), .DUAL_PORT(1'b1), .DMA_ATTACHED(1'b1)) DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .mem_req_i(req), .mem_we_i(we),
        .mem_addr_i(addr), .mem_wdata_i(wdata), .mem_rdata_o(rdata), .mem_rvalid_o(rvalid),
        .check_en_i(check_en), .access_setup_i(setup), .port_a_go_i(go_a), .port_b_go_i(go_b),
        .target_addr_i(taddr), .write_word_regs_i(wword), .write_check_i(wchk),
        .wdog_en_i(wdog_en), .mem_alive_i(alive), .sbe_clear_i(sbe_clr), .dbe_clear_i(dbe_clr),
        .tmo_clear_i(tmo_clr), .ind_busy_o(busy), .ind_done_o(done), .read_word_o(rword),
        .read_check_reg_lo_o(chk_lo), .read_check_reg_hi_o(chk_hi), .sbe_flag_o(sbe),
        .dbe_flag_o(dbe), .tmo_flag_o(tmo), .err_addr_o(eaddr));

    sre_bus_master #(.DW(DW), .AW(AW)) u_master (.clk_i(clk_i), .req_o(req), .we_o(we),
        .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;

    // ==========================================================
    // Run limit: watchdog test alone needs over 2048 cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    function automatic logic [4:0] enc(input logic [7:0] v);
        logic [4:0] c;
        for (int r = 0; r < 5; r++)
            c[r] = ^(v & ROW[r]);
        return c;
    endfunction : enc

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic mem(input logic w, input logic [3:0] a, input logic [7:0] v);
        u_master.access(w, a, v, q, ok);
        `CHK(ok, ~w)
    endtask : mem

    task automatic ind(input logic [2:0] s, input logic [3:0] a, input logic [7:0] w,
                       input logic [4:0] c, input logic b);
        @(posedge clk_i);
        setup <= sre_setup_t'(s);
        taddr <= a;
        wword <= w;
        wchk <= c;
        go_a <= ~b;
        go_b <= b;
        @(posedge clk_i);
        go_a <= 1'b0;
        go_b <= 1'b0;
        for (int n = 0; n < 20 && done !== 1'b1; n++)
            @(negedge clk_i);
        `CHK(done, 1'b1)
    endtask : ind

    task automatic clr();
        @(posedge clk_i);
        sbe_clr <= 1'b1;
        dbe_clr <= 1'b1;
        @(posedge clk_i);
        sbe_clr <= 1'b0;
        dbe_clr <= 1'b0;
    endtask : clr

    // ==========================================================
    // Main sequence
    initial
    begin
        {resetn_i, go_a, go_b, sbe_clr, dbe_clr, tmo_clr, wdog_en} = '0;
        {taddr, wword, wchk, setup} = '0;
        check_en = 1'b1;
        alive = 1'b1;
        void'($urandom(95));
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        `CHK({busy, done, sbe, dbe, tmo, chk_lo, chk_hi}, 21'h000000)
        // Clean traffic, zero and all-ones among random words
        for (k = 0; k < 16; k++)
        begin
            img[k] = (k == 0) ? 8'h00 : (k == 15) ? 8'hFF : 8'($urandom);
            mem(1'b1, 4'(k), img[k]);
            mem(1'b0, 4'(k), 8'h00);
            `CHK(q, img[k])
            `CHK(chk_lo, {3'h0, enc(img[k])})
        end
        `CHK({sbe, dbe}, 2'b00)
        `CHK(chk_hi, 8'h00)
        // Single flips over every data and check position
        for (k = 0; k < 13; k++)
        begin
            d = 8'($urandom);
            mem(1'b1, 4'h3, d);
            x = (k < 8) ? 8'(1 << k) : 8'h00;
            ind(3'b111, 4'h3, d ^ x, enc(d) ^ 5'((k < 8) ? 0 : 1 << (k - 8)), k[0]);
            mem(1'b0, 4'h3, 8'h00);
            `CHK(q, d)
            `CHK({sbe, dbe, eaddr}, 6'h23)
            clr();
        end
        // Double flips: detected, data left alone
        for (k = 0; k < 8; k++)
        begin
            d = 8'($urandom);
            mem(1'b1, 4'h5, d);
            x = (k < 7) ? 8'h03 << k : 8'h81;
            ind(3'b111, 4'h5, d ^ x, enc(d), k[0]);
            mem(1'b0, 4'h5, 8'h00);
            `CHK(q, d ^ x)
            `CHK({sbe, dbe, eaddr}, 6'h15)
            clr();
        end
        // Checking off keeps the old check bits
        @(posedge clk_i);
        check_en <= 1'b0;
        d = img[7] ^ 8'h5A;
        mem(1'b1, 4'h7, d);
        mem(1'b0, 4'h7, 8'h00);
        `CHK(q, d)
        `CHK({chk_lo, sbe, dbe}, {3'h0, enc(img[7]), 2'b00})
        @(posedge clk_i);
        check_en <= 1'b1;
        mem(1'b0, 4'h7, 8'h00);
        `CHK(sbe | dbe, 1'b1)
        clr();
        // Indirect read, then a write without data override
        ind(3'b000, 4'h9, 8'h00, 5'h00, 1'b1);
        `CHK({rword, chk_lo}, {img[9], 3'h0, enc(img[9])})
        ind(3'b100, 4'h9, ~img[9], 5'h00, 1'b0);
        mem(1'b0, 4'h9, 8'h00);
        `CHK({q, sbe, dbe}, {img[9], 2'b00})
        // Stalled access; a second go while busy is ignored
        @(posedge clk_i);
        alive <= 1'b0;
        wdog_en <= 1'b1;
        go_a <= 1'b1;
        @(posedge clk_i);
        go_a <= 1'b0;
        @(negedge clk_i);
        t0 = cycles;
        repeat (100) @(posedge clk_i);
        go_a <= 1'b1;
        @(posedge clk_i);
        go_a <= 1'b0;
        while (busy === 1'b1 && cycles - t0 < 3000)
            @(negedge clk_i);
        `CHK(cycles - t0, 2048)
        `CHK({tmo, done}, 2'b10)
        @(posedge clk_i);
        tmo_clr <= 1'b1;
        alive <= 1'b1;
        @(posedge clk_i);
        tmo_clr <= 1'b0;
        @(negedge clk_i);
        `CHK(tmo, 1'b0)
        stop_test();
    end
endmodule : sre_secded_ram_tb_top

bind sre_secded_ram sre_secded_ram_props #(.ADDR_W(ADDR_W)) u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .mem_req_i(mem_req_i), .mem_we_i(mem_we_i),
    .mem_addr_i(mem_addr_i), .mem_rvalid_o(mem_rvalid_o), .check_en_i(check_en_i),
    .port_a_go_i(port_a_go_i), .wdog_en_i(wdog_en_i), .mem_alive_i(mem_alive_i),
    .ind_busy_o(ind_busy_o), .ind_done_o(ind_done_o), .sbe_flag_o(sbe_flag_o),
    .dbe_flag_o(dbe_flag_o), .tmo_flag_o(tmo_flag_o), .err_addr_o(err_addr_o));

`default_nettype wire
